//--- common/lu_cfg_pkg.sv
// constants, field layouts and carrier types for the channel config bank
`default_nettype none
package lu_cfg_pkg;
  // ==========================================================
  // register map
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 5;
  localparam int CH_LSB = 3;
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_TX = 3'h1;
  localparam logic [2:0] IDX_DET = 3'h2;
  localparam logic [2:0] IDX_RXF = 3'h3;
  localparam logic [2:0] IDX_RATE = 3'h4;
  localparam logic [4:0] REG_RESET = 5'h00;
  // ==========================================================
  // field positions
  localparam int ST_LOSS_BIT = 3;
  localparam int ST_ALOSS_BIT = 2;
  localparam int ST_DLOSS_BIT = 1;
  localparam int TX_EDGE_BIT = 2;
  localparam int BYPASS_BIT = 1;
  localparam int ADIS_BIT = 2;
  localparam int DDIS_BIT = 1;
  localparam int EQ_BIT = 0;
  localparam int CODEC_BIT = 4;
  localparam int MUTE_BIT = 3;
  localparam int SHUT_BIT = 2;
  localparam int RXEDGE_BIT = 1;
  localparam int STS_BIT = 3;
  localparam int E3_BIT = 2;
  localparam int LLB_BIT = 1;
  localparam int RLB_BIT = 0;
  // writable bits; reserved bits are dropped on write
  localparam logic [4:0] TX_MASK = 5'h06;
  localparam logic [4:0] DET_MASK = 5'h07;
  localparam logic [4:0] RXF_MASK = 5'h1e;
  localparam logic [4:0] RATE_MASK = 5'h0f;
  // ==========================================================
  // types
  typedef enum logic [1:0] {RATE_DS3, RATE_STS1, RATE_E3} rate_t;
  typedef enum logic [1:0] {
    LOOP_NONE, LOOP_ANALOG, LOOP_DIGITAL, LOOP_REMOTE
  } loop_t;
  typedef struct packed {
    logic tx_sample_rising;
    logic build_out_bypass;
    logic analog_det_en;
    logic digital_det_en;
    logic equalizer_enable;
    logic codec_enable;
    logic subst_hdb3;
    logic subst_b3zs;
    logic mute_on_signal_loss;
    logic receiver_shutdown;
    logic rx_launch_falling;
    rate_t rate;
    loop_t loop;
  } chan_cfg_t;
  localparam chan_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, RATE_DS3, LOOP_NONE};
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

//--- design/line_channel_rx.sv
// per-channel loss combining and receive rail output stage
`timescale 1ns/100ps
`default_nettype none
module line_channel_rx (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire lu_cfg_pkg::chan_cfg_t cfg,
  input wire logic analog_loss_pin,
  input wire logic digital_loss_pin,
  input wire logic rx_pos_pin,
  input wire logic rx_neg_pin,
  output var logic [1:0] loss_seen,
  output var logic combined_signal_loss,
  output var logic rx_positive_rail_out,
  output var logic rx_negative_rail_out
);
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic [1:0] seen;
    logic loss;
    logic pos;
    logic neg;
  } chan_state_t;
  chan_state_t st_ff;
  chan_state_t nxt_st;
  logic loss_now;
  logic blank;
  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    // meta is read only by the second stage
    nxt_st.meta = {analog_loss_pin, digital_loss_pin, rx_pos_pin, rx_neg_pin};
    nxt_st.sync = st_ff.meta;
    nxt_st.seen = st_ff.sync[3:2];
    loss_now = (st_ff.sync[3] & cfg.analog_det_en) |
      (st_ff.sync[2] & cfg.digital_det_en); // [RULE7]
    nxt_st.loss = loss_now;
    // muting uses the same loss term so data and flag move together
    blank = cfg.receiver_shutdown |
      (cfg.mute_on_signal_loss & loss_now); // [RULE11] [RULE12]
    nxt_st.pos = st_ff.sync[1] & ~blank;
    nxt_st.neg = st_ff.sync[0] & ~blank & ~cfg.codec_enable; // [RULE9]
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
  assign loss_seen = st_ff.seen;
  assign combined_signal_loss = st_ff.loss;
  assign rx_positive_rail_out = st_ff.pos;
  assign rx_negative_rail_out = st_ff.neg;
  // ==========================================================
  // checks
  loss_quiet_a: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
    clk_en && !st_ff.sync[3] && !st_ff.sync[2] |=> !combined_signal_loss)
    else $error("loss flagged with no detector active");
  loss_digital_a: assert property (@(posedge mclk) // [RULE7]
    disable iff (reset)
    clk_en && st_ff.sync[2] && cfg.digital_det_en |=> combined_signal_loss)
    else $error("enabled digital detector did not raise loss");
  mute_rails_a: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
    clk_en && loss_now && cfg.mute_on_signal_loss
    |=> !rx_positive_rail_out && !rx_negative_rail_out)
    else $error("rails not muted during loss");
  single_rail_a: assert property (@(posedge mclk) disable iff (reset) // [RULE9]
    clk_en && cfg.codec_enable |=> !rx_negative_rail_out)
    else $error("negative rail active in single-rail mode");
endmodule // line_channel_rx
`default_nettype wire

//--- design/line_unit_channel_config_regs.sv
// per-channel command registers and derived channel configuration
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [RULE1] tx edge field 1 samples tx rails on rising clock, 0 on falling
// [RULE2] build-out field high bypasses build-out; low keeps shaped pulses
// [RULE3] software sets build-out field 1 beyond 225 feet of cable
// [RULE4] build-out field acts only in DS3 or STS-1, never in E3
// [RULE5] analog detector disable: 0 enables, 1 disables the detector
// [RULE6] digital detector disable: 0 enables, 1 disables the detector
// [RULE7] combined loss is OR of the enabled detectors only
// [RULE8] equalizer field 1 switches equalizer on, 0 off
// [RULE9] rail field 1 enables codec, single rail, negative rail low
// [RULE10] codec uses HDB3 in E3, B3ZS in DS3 or STS-1
// [RULE11] mute field 1 forces both rx rails to 0 during loss
// [RULE12] shutdown field 1 powers off receive sections, 0 restores
// [RULE13] rx edge field 0 launches on rising clock, 1 on falling
// [RULE14] STS-1 field picks DS3 or STS-1, ignored when E3 set
// [RULE15] E3 field 1 selects E3 mode
// [RULE16] local/remote loop fields pick none, analog, digital, remote
// [RULE17] channel n register k sits at eight n plus k
// [RULE18] all command register fields reset to zero
// [RULE19] reserved bits accept writes and affect nothing
module line_unit_channel_config_regs #(
  parameter int NUM_CH = lu_cfg_pkg::NUM_CH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire lu_cfg_pkg::reg_req_t reg_req,
  output var logic [lu_cfg_pkg::DATA_W-1:0] reg_rdata,
  output var logic reg_rvalid,
  input wire logic [NUM_CH-1:0] analog_signal_loss,
  input wire logic [NUM_CH-1:0] digital_signal_loss,
  input wire logic [NUM_CH-1:0] rx_pos_recovered,
  input wire logic [NUM_CH-1:0] rx_neg_recovered,
  output var lu_cfg_pkg::chan_cfg_t [NUM_CH-1:0] chan_cfg,
  output var logic [NUM_CH-1:0] combined_signal_loss,
  output var logic [NUM_CH-1:0] rx_positive_rail_out,
  output var logic [NUM_CH-1:0] rx_negative_rail_out
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_CH-1:0][4:0] tx;
    logic [NUM_CH-1:0][4:0] det;
    logic [NUM_CH-1:0][4:0] rxf;
    logic [NUM_CH-1:0][4:0] rate;
    lu_cfg_pkg::chan_cfg_t [NUM_CH-1:0] cfg;
    logic [4:0] rdata;
    logic rvalid;
  } bank_state_t;

  localparam bank_state_t ST_RESET = '{
    tx: {NUM_CH{lu_cfg_pkg::REG_RESET}},
    det: {NUM_CH{lu_cfg_pkg::REG_RESET}},
    rxf: {NUM_CH{lu_cfg_pkg::REG_RESET}},
    rate: {NUM_CH{lu_cfg_pkg::REG_RESET}},
    cfg: {NUM_CH{lu_cfg_pkg::CFG_RESET}},
    rdata: 5'h00,
    rvalid: 1'b0
  };

  bank_state_t st_ff;
  bank_state_t nxt_st;
  logic [4:0] rd_val;
  logic [NUM_CH-1:0][1:0] loss_seen;

  // ==========================================================
  // decoding
  function automatic logic hit(
    input logic [lu_cfg_pkg::ADDR_W-1:0] addr,
    input int ch,
    input logic [2:0] idx
  );
    logic [1:0] chb;
    chb = ch[1:0];
    hit = addr == {chb, idx}; // [RULE17]
  endfunction

  // turns raw register bits into the channel's working configuration
  function automatic lu_cfg_pkg::chan_cfg_t cfg_of(
    input logic [4:0] tx,
    input logic [4:0] det,
    input logic [4:0] rxf,
    input logic [4:0] rate
  );
    lu_cfg_pkg::chan_cfg_t c;
    logic e3;
    logic codec;
    c = lu_cfg_pkg::CFG_RESET;
    e3 = rate[lu_cfg_pkg::E3_BIT];
    codec = rxf[lu_cfg_pkg::CODEC_BIT];
    c.tx_sample_rising = tx[lu_cfg_pkg::TX_EDGE_BIT]; // [RULE1]
    // build-out has no meaning at the E3 rate
    c.build_out_bypass = tx[lu_cfg_pkg::BYPASS_BIT] & ~e3; // [RULE2] [RULE4]
    c.analog_det_en = ~det[lu_cfg_pkg::ADIS_BIT]; // [RULE5]
    c.digital_det_en = ~det[lu_cfg_pkg::DDIS_BIT]; // [RULE6]
    c.equalizer_enable = det[lu_cfg_pkg::EQ_BIT]; // [RULE8]
    c.codec_enable = codec; // [RULE9]
    c.subst_hdb3 = codec & e3; // [RULE10]
    c.subst_b3zs = codec & ~e3; // [RULE10]
    c.mute_on_signal_loss = rxf[lu_cfg_pkg::MUTE_BIT]; // [RULE11]
    c.receiver_shutdown = rxf[lu_cfg_pkg::SHUT_BIT]; // [RULE12]
    c.rx_launch_falling = rxf[lu_cfg_pkg::RXEDGE_BIT]; // [RULE13]
    if (e3) begin
      c.rate = lu_cfg_pkg::RATE_E3; // [RULE15]
    end else if (rate[lu_cfg_pkg::STS_BIT]) begin
      c.rate = lu_cfg_pkg::RATE_STS1; // [RULE14]
    end else begin
      c.rate = lu_cfg_pkg::RATE_DS3; // [RULE14]
    end
    unique case ({rate[lu_cfg_pkg::LLB_BIT], rate[lu_cfg_pkg::RLB_BIT]})
      2'b00: c.loop = lu_cfg_pkg::LOOP_NONE; // [RULE16]
      2'b10: c.loop = lu_cfg_pkg::LOOP_ANALOG; // [RULE16]
      2'b11: c.loop = lu_cfg_pkg::LOOP_DIGITAL; // [RULE16]
      2'b01: c.loop = lu_cfg_pkg::LOOP_REMOTE; // [RULE16]
    endcase
    return c;
  endfunction

  // ==========================================================
  // register access and configuration update
  always_comb begin
    nxt_st = st_ff;
    rd_val = 5'h00;
    nxt_st.rvalid = reg_req.rd;
    for (int i = 0; i < NUM_CH; i++) begin
      // reserved positions are masked off so they never steer anything
      if (reg_req.wr && hit(reg_req.addr, i, lu_cfg_pkg::IDX_TX)) begin
        nxt_st.tx[i] = reg_req.wdata & lu_cfg_pkg::TX_MASK; // [RULE19]
      end
      if (reg_req.wr && hit(reg_req.addr, i, lu_cfg_pkg::IDX_DET)) begin
        nxt_st.det[i] = reg_req.wdata & lu_cfg_pkg::DET_MASK; // [RULE19]
      end
      if (reg_req.wr && hit(reg_req.addr, i, lu_cfg_pkg::IDX_RXF)) begin
        nxt_st.rxf[i] = reg_req.wdata & lu_cfg_pkg::RXF_MASK; // [RULE19]
      end
      if (reg_req.wr && hit(reg_req.addr, i, lu_cfg_pkg::IDX_RATE)) begin
        nxt_st.rate[i] = reg_req.wdata & lu_cfg_pkg::RATE_MASK; // [RULE19]
      end
      // config follows the register in the same edge, no extra lag
      nxt_st.cfg[i] = cfg_of(nxt_st.tx[i], nxt_st.det[i],
        nxt_st.rxf[i], nxt_st.rate[i]);
      if (hit(reg_req.addr, i, lu_cfg_pkg::IDX_STATUS)) begin
        rd_val[lu_cfg_pkg::ST_LOSS_BIT] = combined_signal_loss[i];
        rd_val[lu_cfg_pkg::ST_ALOSS_BIT] = loss_seen[i][1];
        rd_val[lu_cfg_pkg::ST_DLOSS_BIT] = loss_seen[i][0];
      end
      if (hit(reg_req.addr, i, lu_cfg_pkg::IDX_TX)) begin
        rd_val = st_ff.tx[i];
      end
      if (hit(reg_req.addr, i, lu_cfg_pkg::IDX_DET)) begin
        rd_val = st_ff.det[i];
      end
      if (hit(reg_req.addr, i, lu_cfg_pkg::IDX_RXF)) begin
        rd_val = st_ff.rxf[i];
      end
      if (hit(reg_req.addr, i, lu_cfg_pkg::IDX_RATE)) begin
        rd_val = st_ff.rate[i];
      end
    end
    // unmapped or spare registers read as zero
    if (reg_req.rd) begin
      nxt_st.rdata = rd_val;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= ST_RESET; // [RULE18]
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign chan_cfg = st_ff.cfg;

  // ==========================================================
  // channel receive stages
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    line_channel_rx u_rx (
      .mclk(mclk),
      .reset(reset),
      .clk_en(clk_en),
      .cfg(st_ff.cfg[g]),
      .analog_loss_pin(analog_signal_loss[g]),
      .digital_loss_pin(digital_signal_loss[g]),
      .rx_pos_pin(rx_pos_recovered[g]),
      .rx_neg_pin(rx_neg_recovered[g]),
      .loss_seen(loss_seen[g]),
      .combined_signal_loss(combined_signal_loss[g]),
      .rx_positive_rail_out(rx_positive_rail_out[g]),
      .rx_negative_rail_out(rx_negative_rail_out[g])
    );
  end

  // ==========================================================
  // checks
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    localparam logic [4:0] A_TX = 5'(8 * g + 1);
    localparam logic [4:0] A_DET = 5'(8 * g + 2);
    localparam logic [4:0] A_RXF = 5'(8 * g + 3);
    localparam logic [4:0] A_RATE = 5'(8 * g + 4);

    tx_edge_a: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
      clk_en && reg_req.wr && reg_req.addr == A_TX
      |=> chan_cfg[g].tx_sample_rising
        == $past(reg_req.wdata[lu_cfg_pkg::TX_EDGE_BIT]))
      else $error("tx sample edge not taken from write");

    bypass_gate_a: assert property (@(posedge mclk) // [RULE2] [RULE4]
      disable iff (reset)
      chan_cfg[g].build_out_bypass
      |-> st_ff.tx[g][lu_cfg_pkg::BYPASS_BIT]
        && chan_cfg[g].rate != lu_cfg_pkg::RATE_E3)
      else $error("build-out bypass active in E3 or unrequested");

    analog_en_a: assert property (@(posedge mclk) // [RULE5]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_DET
      |=> chan_cfg[g].analog_det_en
        != $past(reg_req.wdata[lu_cfg_pkg::ADIS_BIT]))
      else $error("analog detector enable wrong polarity");

    digital_en_a: assert property (@(posedge mclk) // [RULE6]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_DET
      |=> chan_cfg[g].digital_det_en
        != $past(reg_req.wdata[lu_cfg_pkg::DDIS_BIT]))
      else $error("digital detector enable wrong polarity");

    equalizer_a: assert property (@(posedge mclk) // [RULE8]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_DET
      |=> chan_cfg[g].equalizer_enable
        == $past(reg_req.wdata[lu_cfg_pkg::EQ_BIT]))
      else $error("equalizer enable not taken from write");

    codec_sub_a: assert property (@(posedge mclk) // [RULE9] [RULE10]
      disable iff (reset)
      chan_cfg[g].codec_enable
      |-> chan_cfg[g].subst_hdb3
        == (chan_cfg[g].rate == lu_cfg_pkg::RATE_E3)
        && chan_cfg[g].subst_b3zs == !chan_cfg[g].subst_hdb3)
      else $error("codec substitution does not match rate");

    shutdown_a: assert property (@(posedge mclk) disable iff (reset) // [RULE12]
      clk_en && reg_req.wr && reg_req.addr == A_RXF
      |=> chan_cfg[g].receiver_shutdown
        == $past(reg_req.wdata[lu_cfg_pkg::SHUT_BIT]))
      else $error("receiver shutdown not taken from write");

    rx_edge_a: assert property (@(posedge mclk) disable iff (reset) // [RULE13]
      clk_en && reg_req.wr && reg_req.addr == A_RXF
      |=> chan_cfg[g].rx_launch_falling
        == $past(reg_req.wdata[lu_cfg_pkg::RXEDGE_BIT]))
      else $error("rx launch edge not taken from write");

    rate_sel_a: assert property (@(posedge mclk) // [RULE14] [RULE15]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_RATE
      |=> chan_cfg[g].rate == ($past(reg_req.wdata[lu_cfg_pkg::E3_BIT])
        ? lu_cfg_pkg::RATE_E3
        : ($past(reg_req.wdata[lu_cfg_pkg::STS_BIT])
          ? lu_cfg_pkg::RATE_STS1 : lu_cfg_pkg::RATE_DS3)))
      else $error("rate mode decoded wrongly");

    loop_sel_a: assert property (@(posedge mclk) // [RULE16]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_RATE
      && reg_req.wdata[1:0] == 2'h1
      |=> chan_cfg[g].loop == lu_cfg_pkg::LOOP_REMOTE)
      else $error("remote loop not selected");

    loop_none_a: assert property (@(posedge mclk) // [RULE16]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_RATE
      && reg_req.wdata[1:0] == 2'h0
      |=> chan_cfg[g].loop == lu_cfg_pkg::LOOP_NONE)
      else $error("loop selected with both fields clear");

    loop_analog_a: assert property (@(posedge mclk) // [RULE16]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_RATE
      && reg_req.wdata[1:0] == 2'h2
      |=> chan_cfg[g].loop == lu_cfg_pkg::LOOP_ANALOG)
      else $error("analog loop not selected");

    loop_digital_a: assert property (@(posedge mclk) // [RULE16]
      disable iff (reset)
      clk_en && reg_req.wr && reg_req.addr == A_RATE
      && reg_req.wdata[1:0] == 2'h3
      |=> chan_cfg[g].loop == lu_cfg_pkg::LOOP_DIGITAL)
      else $error("digital loop not selected");

    map_read_a: assert property (@(posedge mclk) // [RULE17]
      disable iff (reset)
      clk_en && reg_req.rd && reg_req.addr == A_DET
      |=> reg_rvalid && reg_rdata == $past(st_ff.det[g]))
      else $error("read of detector register wrong");

    map_tx_a: assert property (@(posedge mclk) // [RULE17]
      disable iff (reset)
      clk_en && reg_req.rd && reg_req.addr == A_TX
      |=> reg_rvalid && reg_rdata == $past(st_ff.tx[g]))
      else $error("read of transmit register wrong");

    map_rxf_a: assert property (@(posedge mclk) // [RULE17]
      disable iff (reset)
      clk_en && reg_req.rd && reg_req.addr == A_RXF
      |=> reg_rvalid && reg_rdata == $past(st_ff.rxf[g]))
      else $error("read of receive format register wrong");

    map_rate_a: assert property (@(posedge mclk) // [RULE17]
      disable iff (reset)
      clk_en && reg_req.rd && reg_req.addr == A_RATE
      |=> reg_rvalid && reg_rdata == $past(st_ff.rate[g]))
      else $error("read of rate register wrong");

    reserved_bits_a: assert property (@(posedge mclk) // [RULE19]
      disable iff (reset)
      (st_ff.rxf[g] & ~lu_cfg_pkg::RXF_MASK) == 5'h00
      && (st_ff.rate[g] & ~lu_cfg_pkg::RATE_MASK) == 5'h00)
      else $error("reserved bit stored");

    reset_zero_a: assert property (@(posedge mclk) // [RULE18]
      disable iff (reset)
      $fell(reset) |-> st_ff.tx[g] == 5'h00 && st_ff.det[g] == 5'h00
        && st_ff.rxf[g] == 5'h00 && st_ff.rate[g] == 5'h00)
      else $error("register not zero after reset");
  end

  read_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && !reg_req.rd |=> !reg_rvalid)
    else $error("read valid without request");

  read_valid_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && reg_req.rd |=> reg_rvalid)
    else $error("read valid missing after request");

endmodule // line_unit_channel_config_regs
`default_nettype wire

//--- verification/tb_line_unit_channel_config_regs.sv
// self-checking bench for the channel command register bank
`timescale 1ns/100ps
`default_nettype none
module tb_line_unit_channel_config_regs;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [4:0] addr;
    logic [4:0] wdata;
    logic [4:0] rexp;
  } row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  lu_cfg_pkg::reg_req_t reg_req = '0;
  logic [4:0] reg_rdata;
  logic reg_rvalid;
  logic [3:0] a_loss = 4'h0;
  logic [3:0] d_loss = 4'h0;
  logic [3:0] pos_in = 4'h0;
  logic [3:0] neg_in = 4'h0;
  lu_cfg_pkg::chan_cfg_t [3:0] chan_cfg;
  logic [3:0] loss_out;
  logic [3:0] pos_out;
  logic [3:0] neg_out;
  logic [4:0] sh_tx [4];
  logic [4:0] sh_det [4];
  logic [4:0] sh_rxf [4];
  logic [4:0] sh_rate [4];
  logic [4:0] rd;
  int n_mismatch = 0;
  int cmp_count = 0;
  // reserved bits in the first rows must read back as zero
  row_t rows [16] = '{'{5'h09, 5'h1f, 5'h06}, '{5'h0a, 5'h1f, 5'h07},
    '{5'h0b, 5'h1f, 5'h1e}, '{5'h0c, 5'h1f, 5'h0f}, '{5'h0c, 5'h08, 5'h08},
    '{5'h0c, 5'h00, 5'h00}, '{5'h0c, 5'h02, 5'h02}, '{5'h0c, 5'h01, 5'h01},
    '{5'h0c, 5'h03, 5'h03}, '{5'h0a, 5'h04, 5'h04}, '{5'h0a, 5'h02, 5'h02},
    '{5'h0b, 5'h10, 5'h10}, '{5'h01, 5'h02, 5'h02}, '{5'h1c, 5'h04, 5'h04},
    '{5'h14, 5'h08, 5'h08}, '{5'h1b, 5'h0a, 5'h0a}};

  always #10 mclk = ~mclk;

  line_unit_channel_config_regs #(.NUM_CH(4))
    line_unit_channel_config_regs_inst (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .analog_signal_loss(a_loss), .digital_signal_loss(d_loss),
    .rx_pos_recovered(pos_in), .rx_neg_recovered(neg_in),
    .chan_cfg(chan_cfg), .combined_signal_loss(loss_out),
    .rx_positive_rail_out(pos_out), .rx_negative_rail_out(neg_out)
  );

  // ==========================================================
  // reference model built from the field definitions
  function automatic lu_cfg_pkg::chan_cfg_t cfg_of(input int c);
    lu_cfg_pkg::chan_cfg_t m;
    logic e3;
    e3 = sh_rate[c][2];
    m.tx_sample_rising = sh_tx[c][2];
    m.build_out_bypass = sh_tx[c][1] & ~e3;
    m.analog_det_en = ~sh_det[c][2];
    m.digital_det_en = ~sh_det[c][1];
    m.equalizer_enable = sh_det[c][0];
    m.codec_enable = sh_rxf[c][4];
    m.subst_hdb3 = sh_rxf[c][4] & e3;
    m.subst_b3zs = sh_rxf[c][4] & ~e3;
    m.mute_on_signal_loss = sh_rxf[c][3];
    m.receiver_shutdown = sh_rxf[c][2];
    m.rx_launch_falling = sh_rxf[c][1];
    m.rate = e3 ? lu_cfg_pkg::RATE_E3 :
      (sh_rate[c][3] ? lu_cfg_pkg::RATE_STS1 : lu_cfg_pkg::RATE_DS3);
    case (sh_rate[c][1:0])
      2'b00: m.loop = lu_cfg_pkg::LOOP_NONE;
      2'b10: m.loop = lu_cfg_pkg::LOOP_ANALOG;
      2'b11: m.loop = lu_cfg_pkg::LOOP_DIGITAL;
      default: m.loop = lu_cfg_pkg::LOOP_REMOTE;
    endcase
    return m;
  endfunction

  // ==========================================================
  // compare tasks
  task automatic cmp5(input string what, input logic [4:0] e,
                      input logic [4:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_cfg(input int c);
    cmp_count++;
    if (chan_cfg[c] !== cfg_of(c)) begin
      n_mismatch++;
      $display("[FAIL] chan_cfg[%0d] expected %h seen %h", c, cfg_of(c),
               chan_cfg[c]);
    end
  endtask

  task automatic cmp_all;
    for (int c = 0; c < 4; c++) cmp_cfg(c);
  endtask

  // ==========================================================
  // register access: request held over one taking edge
  task automatic reg_op(input logic w, input logic r, input logic [4:0] a,
                        input logic [4:0] wd, output logic [4:0] d);
    int i;
    @(posedge mclk);
    #1;
    reg_req.wr = w;
    reg_req.rd = r;
    reg_req.addr = a;
    reg_req.wdata = wd;
    @(posedge mclk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    // a frozen clock enable drops the write, so the shadow stays put
    if (w && clk_en) begin
      case (a[2:0])
        3'h1: sh_tx[a[4:3]] = wd & lu_cfg_pkg::TX_MASK;
        3'h2: sh_det[a[4:3]] = wd & lu_cfg_pkg::DET_MASK;
        3'h3: sh_rxf[a[4:3]] = wd & lu_cfg_pkg::RXF_MASK;
        3'h4: sh_rate[a[4:3]] = wd & lu_cfg_pkg::RATE_MASK;
        default: ;
      endcase
    end
    d = 5'h00;
    i = 0;
    while (r && reg_rvalid !== 1'b1 && i < 4) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (r && i == 4) begin
      n_mismatch++;
      $display("[FAIL] reg_rvalid expected 1 seen %b", reg_rvalid);
    end
    if (r) d = reg_rdata;
  endtask

  task automatic clear_shadow;
    for (int c = 0; c < 4; c++) begin
      sh_tx[c] = 5'h00;
      sh_det[c] = 5'h00;
      sh_rxf[c] = 5'h00;
      sh_rate[c] = 5'h00;
    end
  endtask

  // channel 2 loss and rail behaviour for one pin setting
  task automatic loss_case(input logic [4:0] det, input logic [4:0] rxf,
                           input logic a, input logic dl);
    logic l;
    logic kill;
    logic ne;
    reg_op(1'b1, 1'b0, 5'h12, det, rd);
    reg_op(1'b1, 1'b0, 5'h13, rxf, rd);
    a_loss[2] = a;
    d_loss[2] = dl;
    pos_in[2] = 1'b1;
    neg_in[2] = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    l = (a & ~det[2]) | (dl & ~det[1]);
    kill = rxf[2] | (rxf[3] & l);
    ne = ~kill & ~rxf[4];
    cmp5("combined_signal_loss", {4'h0, l}, {4'h0, loss_out[2]});
    cmp5("rx_positive_rail_out", {4'h0, ~kill}, {4'h0, pos_out[2]});
    cmp5("rx_negative_rail_out", {4'h0, ne}, {4'h0, neg_out[2]});
    reg_op(1'b0, 1'b1, 5'h10, 5'h00, rd);
    cmp5("status", {1'b0, l, a, dl, 1'b0}, rd);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(20 * 5000);
    n_mismatch++;
    $display("[FAIL] watchdog expected done seen running");
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    clear_shadow();
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    cmp_all();
    for (int c = 0; c < 4; c++) begin
      for (int k = 1; k < 5; k++) begin
        reg_op(1'b0, 1'b1, 5'(8 * c + k), 5'h00, rd);
        cmp5("reset value", 5'h00, rd);
      end
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      reg_op(1'b1, 1'b0, rows[i].addr, rows[i].wdata, rd);
      cmp_all();
      reg_op(1'b0, 1'b1, rows[i].addr, 5'h00, rd);
      cmp5("readback", rows[i].rexp, rd);
    end
    $display("test register table done");
    // channel 3 sits in E3 here, so the long-cable bypass must stay off
    reg_op(1'b1, 1'b0, 5'h19, 5'h02, rd);
    cmp_all();
    reg_op(1'b1, 1'b0, 5'h1c, 5'h00, rd);
    cmp_all();
    $display("test build-out gating done");
    // status and unused indices must not disturb any channel
    reg_op(1'b1, 1'b0, 5'h0d, 5'h1f, rd);
    reg_op(1'b1, 1'b0, 5'h08, 5'h1f, rd);
    reg_op(1'b1, 1'b0, 5'h17, 5'h1f, rd);
    cmp_all();
    $display("test unmapped writes done");
    // write and read together return the value held before the write
    reg_op(1'b1, 1'b1, 5'h0b, 5'h00, rd);
    cmp5("write with read", 5'h10, rd);
    cmp_all();
    $display("test same cycle access done");
    clk_en = 1'b0;
    reg_op(1'b1, 1'b0, 5'h09, 5'h04, rd);
    @(posedge mclk);
    #1;
    clk_en = 1'b1;
    cmp_all();
    $display("test frozen enable done");
    loss_case(5'h00, 5'h00, 1'b1, 1'b0);
    loss_case(5'h04, 5'h00, 1'b1, 1'b0);
    loss_case(5'h02, 5'h00, 1'b0, 1'b1);
    loss_case(5'h02, 5'h00, 1'b1, 1'b1);
    loss_case(5'h00, 5'h08, 1'b1, 1'b0);
    loss_case(5'h00, 5'h08, 1'b0, 1'b0);
    loss_case(5'h00, 5'h10, 1'b0, 1'b0);
    loss_case(5'h00, 5'h04, 1'b0, 1'b0);
    // leave loss and both rails high so the reset below must clear them
    loss_case(5'h00, 5'h00, 1'b1, 1'b0);
    $display("test loss and rails done");
    @(posedge mclk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    clear_shadow();
    cmp_all();
    cmp5("rails in reset", 5'h00, {3'h0, pos_out[2], neg_out[2]});
    cmp5("loss in reset", 5'h00, {4'h0, loss_out[2]});
    reset = 1'b0;
    reg_op(1'b0, 1'b1, 5'h0c, 5'h00, rd);
    cmp5("rate after reset", 5'h00, rd);
    $display("test second reset done");
    wrap_up();
  end
endmodule // tb_line_unit_channel_config_regs
`default_nettype wire
